// *** verilog/bag_pkg.sv ***
`default_nettype none
package bag_pkg;
   // Branch target forms
   typedef enum logic [2:0] {
      BAG_BR_NONE,
      BAG_BR_REL,
      BAG_BR_IMM16,
      BAG_BR_SHORT11,
      BAG_BR_TABLE,
      BAG_BR_REGPAIR
   } bag_br_mode_t;

   // Operand address forms
   typedef enum logic [3:0] {
      BAG_OP_NONE,
      BAG_OP_IMPLIED,
      BAG_OP_REG,
      BAG_OP_DIRECT,
      BAG_OP_SHORT,
      BAG_OP_SFR,
      BAG_OP_INDIRECT,
      BAG_OP_BASED,
      BAG_OP_INDEXED,
      BAG_OP_STACK
   } bag_op_mode_t;

   // Decoded request from the instruction decoder
   typedef struct packed {
      bag_br_mode_t br_mode;
      bag_op_mode_t op_mode;
      logic [15:0]  imm16;
      logic [7:0]   opcode;
      logic [2:0]   reg_code;
      logic [1:0]   pair_code;
      logic         word_op;
      logic [15:0]  next_pc;
   } bag_req_t;

   // Register file view
   typedef struct packed {
      logic [15:0] accumulator_pair;
      logic [15:0] pointer_pair;
      logic [15:0] base_pair;
      logic [7:0]  reg_b;
      logic [7:0]  reg_c;
      logic [15:0] stack_ptr;
   } bag_regs_t;

   // Operand address result
   typedef struct packed {
      logic [15:0] addr;
      logic [1:0]  bank;
      logic [2:0]  reg_sel;
      logic        is_reg;
      logic        fault;
   } bag_opnd_t;

   localparam logic [15:0] BAG_SHORT11_BASE = 16'h0800;
   localparam logic [15:0] BAG_TABLE_BASE   = 16'h0040;
   localparam logic [15:0] BAG_TABLE_END    = 16'h007f;
   localparam logic [15:0] BAG_SADDR_LO     = 16'hfe20;
   localparam logic [15:0] BAG_SADDR_HI     = 16'hff1f;
   localparam logic [7:0]  BAG_SADDR_SPLIT  = 8'h20;
   localparam logic [6:0]  BAG_UPPER_ONES   = 7'h7f;
   localparam logic [7:0]  BAG_SFR_HIGH     = 8'hff;
   localparam logic [7:0]  BAG_SFR_GAP_LO   = 8'hd0;
   localparam logic [7:0]  BAG_SFR_GAP_HI   = 8'hdf;
   localparam logic [15:0] BAG_HSRAM_LO     = 16'hfb00;
   localparam logic [15:0] BAG_HSRAM_HI     = 16'hfeff;
   localparam logic [2:0]  BAG_REG_X        = 3'h0;
   localparam logic [2:0]  BAG_REG_A        = 3'h1;
   localparam logic [1:0]  BAG_RP_ACC       = 2'h0;
   localparam int          BAG_SIGN_BIT     = 7;
endpackage
`default_nettype wire

// *** verilog/bag_addr_gen.sv ***
`default_nettype none
// Summary of operation
// - Relative branch: next instruction address plus signed byte displacement.
// - Displacement upper bits copy the sign bit.
// - Sixteen-bit immediate call or branch loads immediate straight into PC.
// - Short call target lies in 0800H..0FFFH from 11-bit field.
// - Table call: opcode bits 1..5 pick entry in 0040H..007FH table.
// - Register jump copies accumulator pair into PC.
// - Multiply, divide, decimal adjust, digit rotate use accumulator implicitly.
// - Register operands chosen by 3-bit or pair code within selected bank.
// - Byte registers numbered 0..7, pairs 0..3 from adjacent bytes.
// - Direct addressing uses 16-bit immediate as operand address.
// - Short direct window spans FE20H..FF1FH, RAM then special registers.
// - Short direct bit 8 set when immediate below 20H; upper bits ones.
// - Short direct word operands only at even addresses.
// - Special register space FF00H..FFCFH and FFE0H..FFFFH, words even only.
// - Indirect uses pointer or base pair of the selected bank.
// - Based: zero-extended offset plus base pair, carry dropped.
// - Based indexed: zero-extended B or C plus base pair, carry dropped.
// - Stack accesses use stack pointer; addresses outside high-speed RAM pass through flagged as fault.
module bag_addr_gen
   import bag_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire logic      req_valid,
   input  wire bag_req_t  req,
   input  wire bag_regs_t regs,
   input  wire logic      bank_select_lo,
   input  wire logic      bank_select_hi,
   input  wire logic      mem_rd_valid,
   input  wire logic [7:0] mem_rd_data,
   output logic           busy,
   output logic           pc_load,
   output logic [15:0]    pc_value,
   output logic           opnd_valid,
   output bag_opnd_t      opnd,
   output logic           tbl_rd_req,
   output logic [15:0]    tbl_rd_addr
);

   typedef enum logic [1:0] {BAG_IDLE, BAG_TLO, BAG_THI} bag_state_t;

   bag_state_t  state_reg;
   logic [15:0] tbl_ptr_reg;
   logic [7:0]  tbl_lo_reg;
   logic [15:0] rel_ext;
   logic [15:0] br_target;
   logic        br_now;
   bag_opnd_t   opnd_next;
   logic [15:0] tbl_entry;

   // Sign extension of the displacement
   assign rel_ext = {{8{req.imm16[BAG_SIGN_BIT]}}, req.imm16[7:0]};
   // Entry address from opcode bits 1..5, always inside the vector table
   assign tbl_entry = BAG_TABLE_BASE | {10'h000, req.opcode[5:1], 1'b0};

   // Direct branch targets, computed in one cycle
   always_comb begin
      br_target = 16'h0000;
      br_now    = 1'b0;
      case (req.br_mode)
         BAG_BR_REL: begin
            br_target = 16'(req.next_pc + rel_ext);
            br_now    = 1'b1;
         end
         BAG_BR_IMM16: begin
            br_target = req.imm16;
            br_now    = 1'b1;
         end
         BAG_BR_SHORT11: begin
            br_target = BAG_SHORT11_BASE | {5'h00, req.imm16[10:0]};
            br_now    = 1'b1;
         end
         BAG_BR_REGPAIR: begin
            br_target = regs.accumulator_pair;
            br_now    = 1'b1;
         end
         default: begin
            br_target = 16'h0000;
            br_now    = 1'b0;
         end
      endcase
   end

   // Operand address forming
   always_comb begin
      opnd_next         = '0;
      opnd_next.bank    = {bank_select_hi, bank_select_lo};
      case (req.op_mode)
         BAG_OP_IMPLIED: begin
            // Accumulator byte, or the pair for word divide and products
            opnd_next.is_reg  = 1'b1;
            opnd_next.reg_sel = req.word_op ? {BAG_RP_ACC, 1'b0} : BAG_REG_A;
         end
         BAG_OP_REG: begin
            opnd_next.is_reg  = 1'b1;
            // Pair n is byte registers 2n and 2n+1
            opnd_next.reg_sel = req.word_op ? {req.pair_code, 1'b0} : req.reg_code;
         end
         BAG_OP_DIRECT: begin
            opnd_next.addr = req.imm16;
         end
         BAG_OP_SHORT: begin
            opnd_next.addr = {BAG_UPPER_ONES, (req.imm16[7:0] < BAG_SADDR_SPLIT),
                              req.imm16[7:0]};
            opnd_next.fault = req.word_op & req.imm16[0];
         end
         BAG_OP_SFR: begin
            opnd_next.addr  = {BAG_SFR_HIGH, req.imm16[7:0]};
            // Gap D0H..DFH is not reachable this way
            opnd_next.fault = (req.imm16[7:0] >= BAG_SFR_GAP_LO &&
                               req.imm16[7:0] <= BAG_SFR_GAP_HI) |
                              (req.word_op & req.imm16[0]);
         end
         BAG_OP_INDIRECT: begin
            opnd_next.addr = req.pair_code[0] ? regs.base_pair : regs.pointer_pair;
         end
         BAG_OP_BASED: begin
            opnd_next.addr = 16'(regs.base_pair + {8'h00, req.imm16[7:0]});
         end
         BAG_OP_INDEXED: begin
            opnd_next.addr = 16'(regs.base_pair +
                                 {8'h00, req.reg_code[0] ? regs.reg_b : regs.reg_c});
         end
         BAG_OP_STACK: begin
            opnd_next.addr  = regs.stack_ptr;
            // Flag stack pointers outside high-speed RAM; the address still passes through
            opnd_next.fault = (regs.stack_ptr < BAG_HSRAM_LO) ||
                              (regs.stack_ptr > BAG_HSRAM_HI);
         end
         default: begin
            opnd_next = '0;
         end
      endcase
   end

   // Table walk sequencer: two byte reads, low then high
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg   <= BAG_IDLE;
         tbl_ptr_reg <= 16'h0000;
         tbl_lo_reg  <= 8'h00;
      end else begin
         case (state_reg)
            BAG_IDLE: begin
               if (req_valid && req.br_mode == BAG_BR_TABLE) begin
                  tbl_ptr_reg <= tbl_entry;
                  state_reg   <= BAG_TLO;
               end
            end
            BAG_TLO: begin
               if (mem_rd_valid) begin
                  tbl_lo_reg  <= mem_rd_data;
                  tbl_ptr_reg <= 16'(tbl_ptr_reg + 16'h0001);
                  state_reg   <= BAG_THI;
               end
            end
            BAG_THI: begin
               if (mem_rd_valid) begin
                  state_reg <= BAG_IDLE;
               end
            end
            default: begin
               state_reg <= BAG_IDLE;
            end
         endcase
      end
   end

   // Table read strobe and address, registered
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tbl_rd_req  <= 1'b0;
         tbl_rd_addr <= 16'h0000;
      end else begin
         tbl_rd_req  <= 1'b0;
         if (state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_TABLE) begin
            tbl_rd_req  <= 1'b1;
            tbl_rd_addr <= tbl_entry;
         end else if (state_reg == BAG_TLO && mem_rd_valid) begin
            tbl_rd_req  <= 1'b1;
            tbl_rd_addr <= 16'(tbl_ptr_reg + 16'h0001);
         end
      end
   end

   // Program counter load, one-cycle pulse
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pc_load  <= 1'b0;
         pc_value <= 16'h0000;
      end else begin
         pc_load <= 1'b0;
         if (state_reg == BAG_IDLE && req_valid && br_now) begin
            pc_load  <= 1'b1;
            pc_value <= br_target;
         end else if (state_reg == BAG_THI && mem_rd_valid) begin
            pc_load  <= 1'b1;
            pc_value <= {mem_rd_data, tbl_lo_reg};
         end
      end
   end

   // Operand result, one-cycle valid
   always_ff @(posedge clk) begin
      if (!resetn) begin
         opnd_valid <= 1'b0;
         opnd       <= '0;
      end else begin
         opnd_valid <= 1'b0;
         if (state_reg == BAG_IDLE && req_valid && req.op_mode != BAG_OP_NONE) begin
            opnd_valid <= 1'b1;
            opnd       <= opnd_next;
         end
      end
   end

   // Busy while a table walk is running; new requests are ignored then
   always_ff @(posedge clk) begin
      if (!resetn) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_reg == BAG_IDLE) ? (req_valid && req.br_mode == BAG_BR_TABLE)
                                         : !(state_reg == BAG_THI && mem_rd_valid);
      end
   end

   property p_rel;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_REL)
         |=> pc_load && pc_value == 16'($past(req.next_pc) + $past(rel_ext));
   endproperty
   a_rel: assert property (p_rel) else $error("relative target wrong");

   property p_sign;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_REL && req.imm16[7])
         |=> pc_value == 16'($past(req.next_pc) - 16'(9'h100 - $past(req.imm16[7:0])));
   endproperty
   a_sign: assert property (p_sign) else $error("negative displacement wrong");

   property p_imm;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_IMM16)
         |=> pc_load && pc_value == $past(req.imm16);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate target wrong");

   property p_short11;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_SHORT11)
         |=> pc_value[15:11] == 5'h01 && pc_value[10:0] == $past(req.imm16[10:0]);
   endproperty
   a_short11: assert property (p_short11) else $error("short call out of range");

   sequence s_tbl_start;
      state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_TABLE;
   endsequence
   property p_table;
      @(posedge clk) disable iff (!resetn)
      s_tbl_start |=> tbl_rd_req && tbl_rd_addr >= BAG_TABLE_BASE &&
                      tbl_rd_addr <= BAG_TABLE_END && !tbl_rd_addr[0];
   endproperty
   a_table: assert property (p_table) else $error("table entry address wrong");

   property p_le;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_THI && mem_rd_valid)
         |=> pc_load && pc_value == {$past(mem_rd_data), $past(tbl_lo_reg)};
   endproperty
   a_le: assert property (p_le) else $error("table word order wrong");

   property p_axjmp;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.br_mode == BAG_BR_REGPAIR)
         |=> pc_value == $past(regs.accumulator_pair);
   endproperty
   a_axjmp: assert property (p_axjmp) else $error("register jump wrong");

   property p_saddr;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_SHORT)
         |=> opnd.addr >= BAG_SADDR_LO && opnd.addr <= BAG_SADDR_HI;
   endproperty
   a_saddr: assert property (p_saddr) else $error("short direct outside window");

   property p_based;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_BASED)
         |=> opnd_valid && opnd.addr == 16'($past(regs.base_pair) + $past(req.imm16[7:0]));
   endproperty
   a_based: assert property (p_based) else $error("based address wrong");

   property p_sfr;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_SFR)
         |=> opnd.addr[15:8] == 8'hff && opnd.addr[7:0] == $past(req.imm16[7:0]);
   endproperty
   a_sfr: assert property (p_sfr) else $error("special register address wrong");

   property p_direct;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_DIRECT)
         |=> opnd_valid && !opnd.is_reg && opnd.addr == $past(req.imm16);
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");

   property p_saddr_bit8;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_SHORT)
         |=> opnd.addr[15:9] == 7'h7f && opnd.addr[8] == ($past(req.imm16[7:5]) == 3'h0);
   endproperty
   a_saddr_bit8: assert property (p_saddr_bit8) else $error("short direct bit 8 wrong");

   property p_word_odd;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.word_op && req.imm16[0] &&
       (req.op_mode == BAG_OP_SHORT || req.op_mode == BAG_OP_SFR))
         |=> opnd_valid && opnd.fault;
   endproperty
   a_word_odd: assert property (p_word_odd) else $error("odd word address accepted");

   property p_sfr_gap;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_SFR && !req.word_op)
         |=> opnd.fault == ($past(req.imm16[7:4]) == 4'hd);
   endproperty
   a_sfr_gap: assert property (p_sfr_gap) else $error("special register gap wrong");

   property p_indexed;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_INDEXED)
         |=> opnd.addr == 16'($past(regs.base_pair) +
             ($past(req.reg_code[0]) ? $past(regs.reg_b) : $past(regs.reg_c)));
   endproperty
   a_indexed: assert property (p_indexed) else $error("based indexed address wrong");

   property p_stack;
      @(posedge clk) disable iff (!resetn)
      (state_reg == BAG_IDLE && req_valid && req.op_mode == BAG_OP_STACK)
         |=> opnd.addr == $past(regs.stack_ptr) &&
             (opnd.fault || (opnd.addr >= BAG_HSRAM_LO && opnd.addr <= BAG_HSRAM_HI));
   endproperty
   a_stack: assert property (p_stack) else $error("stack access outside fast RAM");

   // Second table read must go to the odd byte right after the entry
   sequence s_tbl_low;
      state_reg == BAG_TLO && mem_rd_valid;
   endsequence
   property p_tbl_high;
      @(posedge clk) disable iff (!resetn)
      s_tbl_low |=> tbl_rd_req && tbl_rd_addr[0] &&
                    tbl_rd_addr == 16'($past(tbl_rd_addr) + 16'h0001);
   endproperty
   a_tbl_high: assert property (p_tbl_high) else $error("high byte address wrong");

   property p_busy;
      @(posedge clk) disable iff (!resetn)
      busy == (state_reg != BAG_IDLE);
   endproperty
   a_busy: assert property (p_busy) else $error("busy out of step with walk");

endmodule // bag_addr_gen
`default_nettype wire

// *** bench/bag_testbench.sv ***
`default_nettype none
module testbench
   import bag_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk;
   logic        resetn;
   logic        req_valid;
   bag_req_t    req;
   bag_regs_t   rg;
   logic        bank_select_lo;
   logic        bank_select_hi;
   logic        mem_rd_valid;
   logic [7:0]  mem_rd_data;
   logic        busy;
   logic        pc_load;
   logic [15:0] pc_value;
   logic        opnd_valid;
   bag_opnd_t   opnd;
   logic        tbl_rd_req;
   logic [15:0] tbl_rd_addr;
   int          err_total;
   int          n_tests;

   bag_addr_gen DUT (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req),
      .regs(rg), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi),
      .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .busy(busy),
      .pc_load(pc_load), .pc_value(pc_value), .opnd_valid(opnd_valid), .opnd(opnd),
      .tbl_rd_req(tbl_rd_req), .tbl_rd_addr(tbl_rd_addr));

   // 100 ns period
   always #50 clk = ~clk;

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One request strobe; answer pulses stand one cycle only, so look right away
   task issue(input bag_br_mode_t b, input bag_op_mode_t o, input logic [15:0] imm,
              input logic [2:0] rc, input logic [1:0] pc, input logic w);
      @(negedge clk);
      req_valid = 1'b1;
      req.br_mode = b;
      req.op_mode = o;
      req.imm16 = imm;
      req.reg_code = rc;
      req.pair_code = pc;
      req.word_op = w;
      @(negedge clk);
      req_valid = 1'b0;
   endtask

   task br_chk(input bag_br_mode_t b, input logic [15:0] imm, input logic [15:0] exp);
      issue(b, BAG_OP_NONE, imm, 3'h0, 2'h0, 1'b0);
      chk(pc_load, 1'b1);
      chk(pc_value, exp);
      chk(opnd_valid, 1'b0);
   endtask

   task op_chk(input bag_op_mode_t o, input logic [15:0] imm, input logic [2:0] rc,
               input logic [1:0] pc, input logic w, input logic [15:0] exp, input logic f);
      issue(BAG_BR_NONE, o, imm, rc, pc, w);
      chk(opnd_valid, 1'b1);
      chk(pc_load, 1'b0);
      chk(opnd.addr, exp);
      chk(opnd.is_reg, 1'b0);
      chk(opnd.fault, f);
      chk(opnd.bank, {bank_select_hi, bank_select_lo});
   endtask

   task reg_chk(input bag_op_mode_t o, input logic [2:0] rc, input logic [1:0] pc,
                input logic w, input logic [2:0] exp);
      issue(BAG_BR_NONE, o, 16'h0000, rc, pc, w);
      chk(opnd_valid, 1'b1);
      chk(opnd.is_reg, 1'b1);
      chk(opnd.reg_sel, exp);
      chk(opnd.bank, 2'h1);
   endtask

   // Branch target forms, sign edges and ignored upper call bits
   task t_branches;
      br_chk(BAG_BR_REL, 16'h007f, 16'h107f);
      br_chk(BAG_BR_REL, 16'h0080, 16'h0f80);
      br_chk(BAG_BR_IMM16, 16'hbeef, 16'hbeef);
      br_chk(BAG_BR_SHORT11, 16'hffff, 16'h0fff);
      br_chk(BAG_BR_SHORT11, 16'h0000, 16'h0800);
      br_chk(BAG_BR_REGPAIR, 16'h0000, 16'h1234);
   endtask

   // Memory operand forms, window edges and misaligned words
   task t_operands;
      op_chk(BAG_OP_DIRECT, 16'hbeef, 3'h0, 2'h0, 1'b0, 16'hbeef, 1'b0);
      op_chk(BAG_OP_SHORT, 16'h0020, 3'h0, 2'h0, 1'b0, 16'hfe20, 1'b0);
      op_chk(BAG_OP_SHORT, 16'h00ff, 3'h0, 2'h0, 1'b0, 16'hfeff, 1'b0);
      op_chk(BAG_OP_SHORT, 16'h001f, 3'h0, 2'h0, 1'b0, 16'hff1f, 1'b0);
      op_chk(BAG_OP_SHORT, 16'h0022, 3'h0, 2'h0, 1'b1, 16'hfe22, 1'b0);
      op_chk(BAG_OP_SHORT, 16'h0021, 3'h0, 2'h0, 1'b1, 16'hfe21, 1'b1);
      op_chk(BAG_OP_SFR, 16'h0020, 3'h0, 2'h0, 1'b0, 16'hff20, 1'b0);
      op_chk(BAG_OP_SFR, 16'h00cf, 3'h0, 2'h0, 1'b0, 16'hffcf, 1'b0);
      op_chk(BAG_OP_SFR, 16'h00d0, 3'h0, 2'h0, 1'b0, 16'hffd0, 1'b1);
      op_chk(BAG_OP_SFR, 16'h00e0, 3'h0, 2'h0, 1'b1, 16'hffe0, 1'b0);
      op_chk(BAG_OP_SFR, 16'h00e1, 3'h0, 2'h0, 1'b1, 16'hffe1, 1'b1);
      op_chk(BAG_OP_INDIRECT, 16'h0000, 3'h0, 2'h0, 1'b0, 16'hfe40, 1'b0);
      op_chk(BAG_OP_INDIRECT, 16'h0000, 3'h0, 2'h1, 1'b0, 16'hfff0, 1'b0);
      op_chk(BAG_OP_BASED, 16'h0080, 3'h0, 2'h0, 1'b0, 16'h0070, 1'b0);
      op_chk(BAG_OP_INDEXED, 16'h0000, 3'h1, 2'h0, 1'b0, 16'h0010, 1'b0);
      op_chk(BAG_OP_INDEXED, 16'h0000, 3'h0, 2'h0, 1'b0, 16'hfff5, 1'b0);
      op_chk(BAG_OP_STACK, 16'h0000, 3'h0, 2'h0, 1'b0, 16'hfc00, 1'b0);
      rg.stack_ptr = 16'hf000;
      op_chk(BAG_OP_STACK, 16'h0000, 3'h0, 2'h0, 1'b0, 16'hf000, 1'b1);
   endtask

   // Register and implied selections in another bank; pairs take their low byte register
   task t_registers;
      bank_select_lo = 1'b1;
      bank_select_hi = 1'b0;
      reg_chk(BAG_OP_REG, 3'h3, 2'h0, 1'b0, 3'h3);
      reg_chk(BAG_OP_REG, 3'h7, 2'h2, 1'b1, 3'h4);
      reg_chk(BAG_OP_IMPLIED, 3'h0, 2'h0, 1'b0, BAG_REG_A);
      reg_chk(BAG_OP_IMPLIED, 3'h0, 2'h0, 1'b1, BAG_REG_X);
   endtask

   // Table walk with a refused request and a late high byte
   task t_table;
      int i;
      @(negedge clk);
      req_valid = 1'b1;
      req.br_mode = BAG_BR_TABLE;
      req.op_mode = BAG_OP_NONE;
      req.opcode = 8'h3e;
      @(negedge clk);
      chk(tbl_rd_req, 1'b1);
      chk(tbl_rd_addr, 16'h007e);
      chk(busy, 1'b1);
      // Low byte comes back while a register jump is still offered; it must be refused
      mem_rd_valid = 1'b1;
      mem_rd_data = 8'h34;
      req.br_mode = BAG_BR_REGPAIR;
      @(negedge clk);
      mem_rd_valid = 1'b0;
      req_valid = 1'b0;
      mem_rd_data = 8'hcb;
      chk(pc_load, 1'b0);
      for (i = 0; i < 8 && tbl_rd_req !== 1'b1; i++)
         @(negedge clk);
      chk(tbl_rd_req, 1'b1);
      chk(tbl_rd_addr, 16'h007f);
      @(negedge clk);
      @(negedge clk);
      mem_rd_valid = 1'b1;
      mem_rd_data = 8'h9a;
      @(negedge clk);
      mem_rd_valid = 1'b0;
      mem_rd_data = 8'h65;
      for (i = 0; i < 8 && pc_load !== 1'b1; i++)
         @(negedge clk);
      chk(pc_load, 1'b1);
      chk(pc_value, 16'h9a34);
      chk(busy, 1'b0);
   endtask

   // Reset in mid-walk must drop the walk; the next request is served at once
   task t_reset_walk;
      @(negedge clk);
      req_valid = 1'b1;
      req.br_mode = BAG_BR_TABLE;
      req.op_mode = BAG_OP_NONE;
      req.opcode = 8'h02;
      @(negedge clk);
      req_valid = 1'b0;
      chk(tbl_rd_addr, 16'h0042);
      resetn = 1'b0;
      @(negedge clk);
      chk(busy, 1'b0);
      chk(tbl_rd_req, 1'b0);
      chk(pc_load, 1'b0);
      resetn = 1'b1;
      br_chk(BAG_BR_IMM16, 16'h0ffe, 16'h0ffe);
   endtask

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      req.next_pc = 16'h1000;
      rg = '0;
      rg.accumulator_pair = 16'h1234;
      rg.pointer_pair = 16'hfe40;
      rg.base_pair = 16'hfff0;
      rg.reg_b = 8'h20;
      rg.reg_c = 8'h05;
      rg.stack_ptr = 16'hfc00;
      bank_select_lo = 1'b0;
      bank_select_hi = 1'b1;
      mem_rd_valid = 1'b0;
      mem_rd_data = 8'h00;
      err_total = 0;
      n_tests = 0;
      repeat (5) @(negedge clk);
      chk(pc_load, 1'b0);
      chk(opnd_valid, 1'b0);
      chk(busy, 1'b0);
      resetn = 1'b1;
      t_branches;
      t_operands;
      t_registers;
      t_table;
      t_reset_walk;
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
